// ### hdl/sop_pkg.sv
// Contract
// - Normal modes: time-protected option fields written once, within 64 cycles of reset.
// - Special modes: time-protected option fields writable any number of times.
// - Converter power output follows the converter power bit.
// - Pump clock from internal RC when select bit is one, else E clock.
// - Interrupt pin falling-edge sensitive when sense bit is one, else low level.
// - Stop exit waits 4064 cycles when delay bit set, else about four.
// - Active clock monitor starts clock failure reset on a slow or stopped clock.
// - Normal modes: forced monitor bit keeps the monitor on until reset; else follows enable bit.
// - Indicator pin driven high briefly only in expanded or test modes with drive bit.
// - Port C outputs open-drain when the open-drain bit is one.
// - Stretch off-chip accesses to the lower or upper half by one cycle.
// - Read-visibility resets to one in special test, unlimited writes; else zero, once.
// - Expanded modes: read visibility drives internal read data onto the external bus.
// - Single chip modes: read visibility holds the E pin low.
// - Serial data least significant bit first when the bit-order bit is one.
// - Extra serial divider bit inserts a divide-by-four stage.
// - Normal modes: protect bits cleared once within 64 cycles; set anytime, held till reset.
// - Bulk protect bit refuses bulk and row erase.
// - Configuration protect refuses configuration writes, except in special modes.
// - Block protect bits guard five address ranges of the EEPROM page.
// - Timer interrupt requested when a flag and its matching enable are both set.
// - Timer prescale 1, 4, 8, 16; code time-protected like the option fields.
package sop_pkg;
	// ==================== Register offsets
	localparam logic [7:0] SOP_TMSK_OFF = 8'h24;
	localparam logic [7:0] SOP_EEPROM_BLOCK_PROTECT_OFF = 8'h35;
	localparam logic [7:0] SOP_SYSTEM_OPTIONS_TWO_OFF = 8'h38;
	localparam logic [7:0] SOP_OPT1_OFF = 8'h39;
	// ==================== Reset values
	localparam logic [7:0] SOP_TMSK_RST = 8'h00;
	localparam logic [7:0] SOP_EEPROM_BLOCK_PROTECT_RST = 8'hbf;
	localparam logic [7:0] SOP_SYSTEM_OPTIONS_TWO_RST = 8'h00;
	localparam logic [7:0] SOP_OPT1_RST = 8'h10;
	// ==================== Field masks
	localparam logic [7:0] SOP_OPT1_TP_MASK = 8'h37;
	localparam logic [7:0] SOP_SYSTEM_OPTIONS_TWO_MASK = 8'hfc;
	localparam logic [7:0] SOP_EEPROM_BLOCK_PROTECT_MASK = 8'hbf;
	localparam logic [7:0] SOP_TMSK_EN_MASK = 8'hf0;
	localparam logic [7:0] SOP_TMSK_PR_MASK = 8'h03;
	// ==================== Bit positions
	localparam int SOP_CONVERTER_POWER_UP_BIT = 7;
	localparam int SOP_PUMP_CLOCK_SELECT_BIT = 6;
	localparam int SOP_INTERRUPT_EDGE_SENSE_BIT = 5;
	localparam int SOP_DLY_BIT = 4;
	localparam int SOP_CME_BIT = 3;
	localparam int SOP_FORCED_CLOCK_MONITOR_BIT = 2;
	localparam int SOP_WAKE_INDICATOR_DRIVE_BIT = 7;
	localparam int SOP_PORT_OPEN_DRAIN_MODE_BIT = 6;
	localparam int SOP_EXTERNAL_ACCESS_STRETCH_BIT = 5;
	localparam int SOP_IRV_BIT = 4;
	localparam int SOP_SERIAL_BIT_ORDER_BIT = 3;
	localparam int SOP_EXTRA_SERIAL_CLOCK_DIVIDER_BIT = 2;
	localparam int SOP_BULK_ERASE_PROTECT_BIT = 7;
	localparam int SOP_CONFIGURATION_PROTECT_BIT = 4;
	localparam int SOP_BPRT4_BIT = 5;
	// ==================== Timing
	localparam int SOP_PROT_WINDOW = 64;
	localparam int SOP_STOP_DELAY = 4064;
	localparam int SOP_STOP_FAST = 4;
	// ==================== EEPROM block bounds (low 12 bits)
	localparam logic [11:0] SOP_BLK0_LO = 12'hd80;
	localparam logic [11:0] SOP_BLK1_LO = 12'hda0;
	localparam logic [11:0] SOP_BLK2_LO = 12'hde0;
	localparam logic [11:0] SOP_BLK3_LO = 12'he60;
	localparam logic [11:0] SOP_BLK4_LO = 12'hf80;
	// ==================== Modes and stop-exit states
	typedef enum logic [1:0] {
		SOP_MODE_SINGLE = 2'h0,
		SOP_MODE_EXPANDED = 2'h1,
		SOP_MODE_BOOT = 2'h2,
		SOP_MODE_TEST = 2'h3
	} sop_mode_type;
	typedef enum logic [1:0] {
		SOP_ST_RUN = 2'h0,
		SOP_ST_WAIT = 2'h1,
		SOP_ST_DONE = 2'h3
	} sop_stop_type;
endpackage

// ### hdl/sop_regs.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module sop_regs #(
	parameter int STOP_DELAY_CYC = sop_pkg::SOP_STOP_DELAY
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [1:0] mode_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic rom_placement_bit_i,
	input wire logic [3:0] timer_flags_i,
	input wire logic clock_slow_i,
	input wire logic stop_exit_req_i,
	input wire logic [15:0] ee_addr_i,
	input wire logic ee_write_i,
	input wire logic ee_bulk_row_erase_i,
	input wire logic config_write_i,
	input wire logic ext_access_i,
	input wire logic [15:0] ext_addr_i,
	input wire logic internal_read_i,
	input wire logic [7:0] internal_data_i,
	input wire logic rc_clk_i,
	input wire logic e_clk_i,
	output logic converter_power_up_o,
	output logic pump_clk_o,
	output logic interrupt_edge_sense_o,
	output logic clock_monitor_active_o,
	output logic clock_fail_reset_o,
	output logic [1:0] watchdog_rate_select_o,
	output logic stop_resume_o,
	output logic instruction_indicator_high_en_o,
	output logic port_open_drain_mode_o,
	output logic stretch_access_o,
	output logic [7:0] ext_data_o,
	output logic ext_data_oe_o,
	output logic e_pin_hold_low_o,
	output logic serial_bit_order_o,
	output logic extra_serial_clock_divider_o,
	output logic ee_write_ok_o,
	output logic ee_erase_ok_o,
	output logic config_write_ok_o,
	output logic timer_irq_o,
	output logic [4:0] timer_prescale_div_o
);
	import sop_pkg::*;

	// ==================== Mode pin synchroniser
	logic [1:0] mode_s1_r, mode_s2_r, mode_s3_r;
	logic [1:0] mode_r, mode_nxt;
	always_comb begin
		mode_nxt = mode_r;
		if (mode_s2_r == mode_s3_r) begin
			mode_nxt = mode_s3_r;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (ce_i) begin
			mode_s1_r <= mode_i;
			mode_s2_r <= mode_s1_r;
			mode_s3_r <= mode_s2_r;
			mode_r <= mode_nxt;
		end
	end

	// ==================== Mode decode
	logic special;
	logic normal;
	logic expanded_like;
	logic single_like;
	assign special = mode_nxt[1];
	assign normal = ~mode_nxt[1];
	assign expanded_like = mode_nxt[0];
	assign single_like = ~mode_nxt[0];

	// ==================== Window counter and write-once tracking
	logic [6:0] win_r, win_nxt;
	logic opt1_once_r, opt1_once_nxt;
	logic irv_once_r, irv_once_nxt;
	logic eeprom_block_protect_once_r, eeprom_block_protect_once_nxt;
	logic pr_once_r, pr_once_nxt;
	logic [7:0] opt1_r, opt1_nxt;
	logic [7:0] system_options_two_r, system_options_two_nxt;
	logic [7:0] eeprom_block_protect_r, eeprom_block_protect_nxt;
	logic [7:0] tmsk_r, tmsk_nxt;
	logic forced_clock_monitor_seen_r, forced_clock_monitor_seen_nxt;
	logic init_r, init_nxt;
	logic in_window;
	logic wr_opt1, wr_system_options_two, wr_eeprom_block_protect, wr_tmsk;
	logic [7:0] eeprom_block_protect_clr_ok;

	assign in_window = (win_r < 7'(SOP_PROT_WINDOW));
	assign wr_opt1 = wr_i && (addr_i == SOP_OPT1_OFF);
	assign wr_system_options_two = wr_i && (addr_i == SOP_SYSTEM_OPTIONS_TWO_OFF);
	assign wr_eeprom_block_protect = wr_i && (addr_i == SOP_EEPROM_BLOCK_PROTECT_OFF);
	assign wr_tmsk = wr_i && (addr_i == SOP_TMSK_OFF);

	always_comb begin
		win_nxt = win_r;
		opt1_once_nxt = opt1_once_r;
		irv_once_nxt = irv_once_r;
		eeprom_block_protect_once_nxt = eeprom_block_protect_once_r;
		pr_once_nxt = pr_once_r;
		opt1_nxt = opt1_r;
		system_options_two_nxt = system_options_two_r;
		eeprom_block_protect_nxt = eeprom_block_protect_r;
		tmsk_nxt = tmsk_r;
		forced_clock_monitor_seen_nxt = forced_clock_monitor_seen_r;
		init_nxt = 1'b1;
		eeprom_block_protect_clr_ok = 8'h00;
		if (in_window) begin
			win_nxt = win_r + 7'h01;
		end
		// Read-visibility reset value depends on mode, caught after reset release
		if (!init_r) begin
			system_options_two_nxt[SOP_IRV_BIT] = (mode_nxt == SOP_MODE_TEST);
		end
		if (wr_opt1) begin
			opt1_nxt = (opt1_r & SOP_OPT1_TP_MASK) | (wdata_i & ~SOP_OPT1_TP_MASK);
			if (special || (in_window && !opt1_once_r)) begin
				opt1_nxt = wdata_i;
				opt1_once_nxt = 1'b1;
			end
		end
		// Forced monitor sticks once set until reset, in normal modes only
		if (opt1_nxt[SOP_FORCED_CLOCK_MONITOR_BIT]) begin
			forced_clock_monitor_seen_nxt = 1'b1;
		end
		if (forced_clock_monitor_seen_r && normal) begin
			opt1_nxt[SOP_FORCED_CLOCK_MONITOR_BIT] = 1'b1;
		end
		if (wr_system_options_two) begin
			system_options_two_nxt = (wdata_i & SOP_SYSTEM_OPTIONS_TWO_MASK & ~8'h10) | (system_options_two_r & 8'h10);
			if (mode_nxt == SOP_MODE_TEST || !irv_once_r) begin
				system_options_two_nxt[SOP_IRV_BIT] = wdata_i[SOP_IRV_BIT];
				irv_once_nxt = 1'b1;
			end
		end
		if (wr_eeprom_block_protect) begin
			// Setting always allowed; clearing only once in window, or in special modes
			if (special || (in_window && !eeprom_block_protect_once_r)) begin
				eeprom_block_protect_clr_ok = SOP_EEPROM_BLOCK_PROTECT_MASK;
				eeprom_block_protect_once_nxt = 1'b1;
			end
			eeprom_block_protect_nxt = ((eeprom_block_protect_r | wdata_i) & ~(eeprom_block_protect_clr_ok & ~wdata_i)) & SOP_EEPROM_BLOCK_PROTECT_MASK;
		end
		if (wr_tmsk) begin
			tmsk_nxt = (wdata_i & SOP_TMSK_EN_MASK) | (tmsk_r & SOP_TMSK_PR_MASK);
			if (special || (in_window && !pr_once_r)) begin
				tmsk_nxt[1:0] = wdata_i[1:0];
				pr_once_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			win_r <= 7'h00;
			opt1_once_r <= 1'b0;
			irv_once_r <= 1'b0;
			eeprom_block_protect_once_r <= 1'b0;
			pr_once_r <= 1'b0;
			opt1_r <= SOP_OPT1_RST;
			system_options_two_r <= SOP_SYSTEM_OPTIONS_TWO_RST;
			eeprom_block_protect_r <= SOP_EEPROM_BLOCK_PROTECT_RST;
			tmsk_r <= SOP_TMSK_RST;
			forced_clock_monitor_seen_r <= 1'b0;
			init_r <= 1'b0;
		end else if (ce_i) begin
			win_r <= win_nxt;
			opt1_once_r <= opt1_once_nxt;
			irv_once_r <= irv_once_nxt;
			eeprom_block_protect_once_r <= eeprom_block_protect_once_nxt;
			pr_once_r <= pr_once_nxt;
			opt1_r <= opt1_nxt;
			system_options_two_r <= system_options_two_nxt;
			eeprom_block_protect_r <= eeprom_block_protect_nxt;
			tmsk_r <= tmsk_nxt;
			forced_clock_monitor_seen_r <= forced_clock_monitor_seen_nxt;
			init_r <= init_nxt;
		end
	end

	// ==================== Read port
	logic [7:0] rdata_nxt;
	always_comb begin
		rdata_nxt = 8'h00;
		if (rd_i) begin
			unique case (addr_i)
				SOP_TMSK_OFF: rdata_nxt = tmsk_r;
				SOP_EEPROM_BLOCK_PROTECT_OFF: rdata_nxt = eeprom_block_protect_r;
				SOP_SYSTEM_OPTIONS_TWO_OFF: rdata_nxt = system_options_two_r;
				SOP_OPT1_OFF: rdata_nxt = opt1_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (ce_i) begin
			rdata_o <= rdata_nxt;
		end
	end

	// ==================== Stop exit delay
	sop_stop_type st_r, st_nxt;
	logic [12:0] dly_r, dly_nxt;
	always_comb begin
		st_nxt = st_r;
		dly_nxt = dly_r;
		unique case (st_r)
			SOP_ST_RUN: begin
				if (stop_exit_req_i) begin
					st_nxt = SOP_ST_WAIT;
					dly_nxt = opt1_r[SOP_DLY_BIT] ? 13'(STOP_DELAY_CYC - 1)
						: 13'(SOP_STOP_FAST - 1);
				end
			end
			SOP_ST_WAIT: begin
				if (dly_r == 13'h0000) begin
					st_nxt = SOP_ST_DONE;
				end else begin
					dly_nxt = dly_r - 13'h0001;
				end
			end
			SOP_ST_DONE: st_nxt = SOP_ST_RUN;
			default: st_nxt = SOP_ST_RUN;
		endcase
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= SOP_ST_RUN;
			dly_r <= 13'h0000;
		end else if (ce_i) begin
			st_r <= st_nxt;
			dly_r <= dly_nxt;
		end
	end
	assign stop_resume_o = (st_r == SOP_ST_DONE);

	// ==================== Option outputs
	logic mon_active;
	assign mon_active = opt1_r[SOP_CME_BIT] | opt1_r[SOP_FORCED_CLOCK_MONITOR_BIT];
	assign converter_power_up_o = opt1_r[SOP_CONVERTER_POWER_UP_BIT];
	assign pump_clk_o = opt1_r[SOP_PUMP_CLOCK_SELECT_BIT] ? rc_clk_i : e_clk_i;
	assign interrupt_edge_sense_o = opt1_r[SOP_INTERRUPT_EDGE_SENSE_BIT];
	assign clock_monitor_active_o = mon_active;
	assign clock_fail_reset_o = mon_active & clock_slow_i;
	assign watchdog_rate_select_o = opt1_r[1:0];
	assign instruction_indicator_high_en_o = system_options_two_r[SOP_WAKE_INDICATOR_DRIVE_BIT] & expanded_like;
	assign port_open_drain_mode_o = system_options_two_r[SOP_PORT_OPEN_DRAIN_MODE_BIT];
	assign stretch_access_o = system_options_two_r[SOP_EXTERNAL_ACCESS_STRETCH_BIT] & expanded_like & ext_access_i
		& (ext_addr_i[15] == ~rom_placement_bit_i);
	assign ext_data_o = internal_data_i;
	assign ext_data_oe_o = expanded_like & system_options_two_r[SOP_IRV_BIT] & internal_read_i;
	assign e_pin_hold_low_o = single_like & system_options_two_r[SOP_IRV_BIT];
	assign serial_bit_order_o = system_options_two_r[SOP_SERIAL_BIT_ORDER_BIT];
	assign extra_serial_clock_divider_o = system_options_two_r[SOP_EXTRA_SERIAL_CLOCK_DIVIDER_BIT];

	// ==================== EEPROM protection
	logic [11:0] ea;
	logic [4:0] blk_hit;
	assign ea = ee_addr_i[11:0];
	assign blk_hit[0] = (ea >= SOP_BLK0_LO) && (ea < SOP_BLK1_LO);
	assign blk_hit[1] = (ea >= SOP_BLK1_LO) && (ea < SOP_BLK2_LO);
	assign blk_hit[2] = (ea >= SOP_BLK2_LO) && (ea < SOP_BLK3_LO);
	assign blk_hit[3] = (ea >= SOP_BLK3_LO) && (ea < SOP_BLK4_LO);
	assign blk_hit[4] = (ea >= SOP_BLK4_LO);
	logic [4:0] blk_prot;
	assign blk_prot = {eeprom_block_protect_r[SOP_BPRT4_BIT], eeprom_block_protect_r[3:0]};
	assign ee_write_ok_o = ee_write_i & ~|(blk_hit & blk_prot);
	assign ee_erase_ok_o = ee_bulk_row_erase_i & ~eeprom_block_protect_r[SOP_BULK_ERASE_PROTECT_BIT];
	assign config_write_ok_o = config_write_i & (special | ~eeprom_block_protect_r[SOP_CONFIGURATION_PROTECT_BIT]);

	// ==================== Timer interrupt and prescale
	assign timer_irq_o = |(tmsk_r[7:4] & timer_flags_i);
	always_comb begin
		unique case (tmsk_r[1:0])
			2'h0: timer_prescale_div_o = 5'h01;
			2'h1: timer_prescale_div_o = 5'h04;
			2'h2: timer_prescale_div_o = 5'h08;
			2'h3: timer_prescale_div_o = 5'h10;
		endcase
	end

	// ==================== Assertions
	AST_OPT1_LOCK: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && normal && !in_window && wr_opt1) |=> $stable(opt1_r[1:0]))
		else $error("Protected option bits changed after window");
	AST_SPECIAL_WR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && special && wr_opt1) |=> (opt1_r[5:4] == $past(wdata_i[5:4])))
		else $error("Special mode option write lost");
	AST_CONVERTER_POWER_UP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		converter_power_up_o == opt1_r[7])
		else $error("Converter power mismatch");
	AST_MON: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(clock_slow_i && opt1_r[SOP_CME_BIT]) |-> clock_fail_reset_o)
		else $error("Clock fail reset missing");
	AST_FORCED_CLOCK_MONITOR_STICK: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(normal && opt1_r[SOP_FORCED_CLOCK_MONITOR_BIT]) |=> opt1_r[SOP_FORCED_CLOCK_MONITOR_BIT])
		else $error("Forced monitor cleared");
	AST_STOP_FAST: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && st_r == SOP_ST_RUN && stop_exit_req_i && !opt1_r[SOP_DLY_BIT])
		|-> ##[1:8] stop_resume_o)
		else $error("Fast stop exit too slow");
	AST_EEPROM_BLOCK_PROTECT_SET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && wr_eeprom_block_protect) |=> ((eeprom_block_protect_r & $past(wdata_i) & SOP_EEPROM_BLOCK_PROTECT_MASK)
		== ($past(wdata_i) & SOP_EEPROM_BLOCK_PROTECT_MASK)))
		else $error("Protect bit set was lost");
	AST_BULK: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		eeprom_block_protect_r[7] |-> !ee_erase_ok_o)
		else $error("Erase allowed while protected");
	AST_TIRQ: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(tmsk_r[7] && timer_flags_i[3]) |-> timer_irq_o)
		else $error("Overflow interrupt missing");
	AST_PR_LOCK: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && normal && pr_once_r && wr_tmsk) |=> $stable(tmsk_r[1:0]))
		else $error("Prescale rewritten");
	AST_PR_WIN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && normal && !in_window && wr_tmsk) |=> $stable(tmsk_r[1:0]))
		else $error("Prescale written after window");
	AST_PR_DIV: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(tmsk_r[1:0] == 2'h3) |-> (timer_prescale_div_o == 5'h10))
		else $error("Prescale divide wrong");
	AST_WIN_OPEN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && normal && in_window && !opt1_once_r && wr_opt1)
		|=> (opt1_r[1:0] == $past(wdata_i[1:0])))
		else $error("First option write in window lost");
	AST_EEPROM_BLOCK_PROTECT_CLR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && normal && (eeprom_block_protect_once_r || !in_window) && wr_eeprom_block_protect)
		|=> ((eeprom_block_protect_r & $past(eeprom_block_protect_r)) == $past(eeprom_block_protect_r)))
		else $error("Protect bit cleared late");
	AST_IRV_ONCE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && mode_nxt != SOP_MODE_TEST && irv_once_r && wr_system_options_two)
		|=> $stable(system_options_two_r[SOP_IRV_BIT]))
		else $error("Read visibility written twice");
	AST_CONFIGURATION_PROTECT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(!special && eeprom_block_protect_r[SOP_CONFIGURATION_PROTECT_BIT]) |-> !config_write_ok_o)
		else $error("Configuration write while protected");
	AST_CFG_SPECIAL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(special && config_write_i) |-> config_write_ok_o)
		else $error("Configuration write refused in special mode");
	AST_BLK_TOP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ee_write_i && ea >= SOP_BLK4_LO && eeprom_block_protect_r[SOP_BPRT4_BIT]) |-> !ee_write_ok_o)
		else $error("Write to protected top block");
	AST_RVIS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(expanded_like && system_options_two_r[SOP_IRV_BIT] && internal_read_i) |-> ext_data_oe_o)
		else $error("Internal read not visible");
	AST_E_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		single_like |-> (e_pin_hold_low_o == system_options_two_r[SOP_IRV_BIT]))
		else $error("E pin hold mismatch");
	AST_LIR_SINGLE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		single_like |-> !instruction_indicator_high_en_o)
		else $error("Indicator drive in single chip mode");
	AST_STRETCH_SINGLE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		single_like |-> !stretch_access_o)
		else $error("Stretch in single chip mode");
	AST_RESUME_PULSE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ce_i && stop_resume_o) |=> !stop_resume_o)
		else $error("Resume pulse too long");

	COV_WIN_WR: cover property (@(posedge sys_clk_i) ce_i && in_window && wr_opt1);
	COV_LATE_WR: cover property (@(posedge sys_clk_i) ce_i && !in_window && wr_eeprom_block_protect);
	COV_STOP: cover property (@(posedge sys_clk_i) stop_resume_o);
	COV_SPECIAL_PR: cover property (@(posedge sys_clk_i) ce_i && special && wr_tmsk);
	COV_CE_HOLD: cover property (@(posedge sys_clk_i) !ce_i && wr_i);
endmodule

// ### test/sop_regs_tb_top.sv
`timescale 1ns/1ps
module sop_regs_tb_top;
	import sop_pkg::*;
	// ==================== Signals
	localparam int STOPD = 20;
	logic sys_clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
	logic [1:0] mode_i = 2'h0;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, internal_data_i = 8'h00, ext_data_o;
	logic rom_placement_bit_i = 1'b0, clock_slow_i = 1'b0, stop_exit_req_i = 1'b0;
	logic [3:0] timer_flags_i = 4'h0;
	logic [15:0] ee_addr_i = 16'h0d80, ext_addr_i = 16'h0000;
	logic ee_write_i = 1'b1, ee_bulk_row_erase_i = 1'b1, config_write_i = 1'b1;
	logic ext_access_i = 1'b0, internal_read_i = 1'b0, rc_clk_i = 1'b0, e_clk_i = 1'b0;
	logic converter_power_up_o, pump_clk_o, interrupt_edge_sense_o, clock_monitor_active_o;
	logic clock_fail_reset_o, stop_resume_o, instruction_indicator_high_en_o;
	logic port_open_drain_mode_o, stretch_access_o, ext_data_oe_o, e_pin_hold_low_o;
	logic serial_bit_order_o, extra_serial_clock_divider_o, ee_write_ok_o, ee_erase_ok_o;
	logic config_write_ok_o, timer_irq_o;
	logic [1:0] watchdog_rate_select_o;
	logic [4:0] timer_prescale_div_o;
	logic [7:0] m [4];
	logic [7:0] offs [4] = '{8'h24, 8'h35, 8'h38, 8'h39};
	logic [11:0] bend [5] = '{12'hd9f, 12'hddf, 12'he5f, 12'hf7f, 12'hfff};
	logic [3:0] u = 4'h0;
	logic [7:0] mm = 8'h00;
	logic [31:0] seed = 32'h00013595;
	int cyc = 0, tmo = 0, miscompares = 0, num_checks = 0;

	sop_regs #(.STOP_DELAY_CYC(STOPD)) uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.mode_i(mode_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .rom_placement_bit_i(rom_placement_bit_i),
		.timer_flags_i(timer_flags_i), .clock_slow_i(clock_slow_i),
		.stop_exit_req_i(stop_exit_req_i), .ee_addr_i(ee_addr_i), .ee_write_i(ee_write_i),
		.ee_bulk_row_erase_i(ee_bulk_row_erase_i), .config_write_i(config_write_i),
		.ext_access_i(ext_access_i), .ext_addr_i(ext_addr_i), .internal_read_i(internal_read_i),
		.internal_data_i(internal_data_i), .rc_clk_i(rc_clk_i), .e_clk_i(e_clk_i),
		.converter_power_up_o(converter_power_up_o), .pump_clk_o(pump_clk_o),
		.interrupt_edge_sense_o(interrupt_edge_sense_o),
		.clock_monitor_active_o(clock_monitor_active_o), .clock_fail_reset_o(clock_fail_reset_o),
		.watchdog_rate_select_o(watchdog_rate_select_o), .stop_resume_o(stop_resume_o),
		.instruction_indicator_high_en_o(instruction_indicator_high_en_o),
		.port_open_drain_mode_o(port_open_drain_mode_o), .stretch_access_o(stretch_access_o),
		.ext_data_o(ext_data_o), .ext_data_oe_o(ext_data_oe_o),
		.e_pin_hold_low_o(e_pin_hold_low_o), .serial_bit_order_o(serial_bit_order_o),
		.extra_serial_clock_divider_o(extra_serial_clock_divider_o),
		.ee_write_ok_o(ee_write_ok_o), .ee_erase_ok_o(ee_erase_ok_o),
		.config_write_ok_o(config_write_ok_o), .timer_irq_o(timer_irq_o),
		.timer_prescale_div_o(timer_prescale_div_o));

	// ==================== Clock, cycle count and timeout
	initial begin
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) cyc <= 0;
		else cyc <= cyc + 1;
	end
	always @(posedge sys_clk_i) begin
		tmo++;
		if (tmo == 5000) begin
			miscompares++;
			end_sim();
		end
	end

	// ==================== Helpers
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
		return seed;
	endfunction
	function automatic logic [20:0] exp_out();
		logic [4:0] dv;
		case (m[0][1:0])
			2'h0: dv = 5'h01;
			2'h1: dv = 5'h04;
			2'h2: dv = 5'h08;
			default: dv = 5'h10;
		endcase
		return {mode_i[0] & m[2][4] & internal_read_i,
			mode_i[0] & m[2][5] & ext_access_i & (ext_addr_i[15] == ~rom_placement_bit_i),
			(m[3][3] | m[3][2]) & clock_slow_i, mode_i[0] & m[2][7], ~mode_i[0] & m[2][4],
			dv, |(m[0][7:4] & timer_flags_i), (~m[1][4] | mode_i[1]) & config_write_i,
			m[2][2], m[2][3], m[2][6], m[3][1:0], m[3][3] | m[3][2], m[3][5],
			m[3][6] ? rc_clk_i : e_clk_i, m[3][7]};
	endfunction
	task automatic cmp_out(input logic [20:0] g, input logic [20:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR t=%0t outputs %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR t=%0t read %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmp_rng(input int n, input int lo, input int hi);
		num_checks++;
		if (n < lo || n > hi) begin
			miscompares++;
			$display("ERROR t=%0t latency %0d outside %0d..%0d", $time, n, lo, hi);
		end
	endtask

	// ==================== Register port tasks
	task automatic do_reset(input logic [1:0] md);
		@(posedge sys_clk_i);
		mode_i <= md;
		rst_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		m = '{8'h00, 8'hbf, (md == 2'h3) ? 8'h10 : 8'h00, 8'h10};
		u = 4'h0;
		repeat (2) @(posedge sys_clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		@(negedge sys_clk_i);
		cmp_reg(rdata_o, e);
	endtask
	task automatic wr(input int i, input logic [7:0] d);
		logic p;
		@(posedge sys_clk_i);
		addr_i <= offs[i];
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
		p = !mode_i[1] && (u[i] || cyc >= SOP_PROT_WINDOW);
		case (i)
			0: m[0] = p ? ((m[0] & 8'h03) | (d & 8'hf0)) : (d & 8'hf3);
			1: m[1] = p ? (m[1] | (d & 8'hbf)) : (d & 8'hbf);
			2: m[2] = (mode_i != 2'h3 && u[2]) ? ((m[2] & 8'h10) | (d & 8'hec)) : (d & 8'hfc);
			default: m[3] = p ? ((m[3] & 8'h37) | (d & 8'hc8)) : d;
		endcase
		u[i] = (i == 2) ? 1'b1 : (u[i] | (cyc < SOP_PROT_WINDOW));
	endtask

	// ==================== Scenario tasks
	task automatic chk_all();
		logic [31:0] r;
		logic [31:0] r2;
		r = rnd();
		r2 = rnd();
		@(posedge sys_clk_i);
		{ext_addr_i, internal_data_i, internal_read_i, rom_placement_bit_i} <= r[25:0];
		{e_clk_i, rc_clk_i, clock_slow_i, timer_flags_i, ext_access_i} <= r2[7:0];
		{ee_write_i, ee_bulk_row_erase_i, config_write_i} <= r[28:26];
		@(negedge sys_clk_i);
		cmp_out({ext_data_oe_o, stretch_access_o, clock_fail_reset_o, instruction_indicator_high_en_o,
			e_pin_hold_low_o, timer_prescale_div_o, timer_irq_o, config_write_ok_o,
			extra_serial_clock_divider_o, serial_bit_order_o, port_open_drain_mode_o,
			watchdog_rate_select_o, clock_monitor_active_o, interrupt_edge_sense_o, pump_clk_o,
			converter_power_up_o}, exp_out());
		cmp_reg(ext_data_o, internal_data_i);
		for (int k = 0; k < 5; k++) begin
			@(posedge sys_clk_i);
			ee_addr_i <= {r2[11:8], bend[k]};
			@(negedge sys_clk_i);
			cmp_out({20'h0, ee_write_ok_o}, {20'h0, ee_write_i & ~m[1][(k < 4) ? k : 5]});
		end
		if (m[1][7] || (m[1] & 8'h2f) == 8'h00) begin
			cmp_out({20'h0, ee_erase_ok_o}, {20'h0, ee_bulk_row_erase_i & ~m[1][7]});
		end
		for (int i = 0; i < 4; i++) rd(offs[i], m[i]);
	endtask
	task automatic stop_chk();
		int n;
		int lo;
		int hi;
		lo = m[3][4] ? STOPD - 2 : 1;
		hi = m[3][4] ? STOPD + 6 : SOP_STOP_FAST + 2;
		@(posedge sys_clk_i);
		stop_exit_req_i <= 1'b1;
		@(posedge sys_clk_i);
		stop_exit_req_i <= 1'b0;
		n = 0;
		@(negedge sys_clk_i);
		while (stop_resume_o !== 1'b1 && n < 100) begin
			@(negedge sys_clk_i);
			n++;
		end
		cmp_rng(n, lo, hi);
	endtask
	task automatic rnd_round();
		for (int i = 0; i < 4; i++) wr(i, 8'(rnd()));
	endtask
	task automatic end_sim();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// ==================== Main sequence
	initial begin
		for (int md = 0; md < 4; md++) begin
			do_reset(md[1:0]);
			for (int i = 0; i < 4; i++) rd(offs[i], m[i]);
			rd(8'h25, 8'h00);
			wr(1, 8'h00);
			rnd_round();
			rnd_round();
			chk_all();
			while (cyc < 80) @(posedge sys_clk_i);
			@(posedge sys_clk_i);
			ce_i <= 1'b0;
			mm = m[2];
			wr(2, ~mm);
			m[2] = mm;
			@(posedge sys_clk_i);
			ce_i <= 1'b1;
			rd(offs[2], m[2]);
			rnd_round();
			chk_all();
			stop_chk();
			if (md == 3) begin
				for (int p = 0; p < 4; p++) begin
					wr(0, {6'h14, p[1:0]});
					wr(3, {3'h0, p[0], 4'h0});
					chk_all();
					stop_chk();
				end
			end
		end
		end_sim();
	end
endmodule
